// File: common/wdtc_pkg.sv
// constants, mode type and period decode for the watchdog control block
// assumes one 20 MHz clock; oscillator ticks arrive as synchronous pulses
//
// What this block does
// - timeout with interrupt enabled sets timeout flag
// - entering watchdog vector clears timeout flag
// - writing one clears flag, zero keeps it
// - interrupt needs flag, enable and global enable
// - reset/interrupt enable pair selects four modes
// - programmed fuse forces system reset mode
// - combined mode: vector entry clears enable, flag
// - combined mode: unserviced second timeout resets system
// - clearing reset enable, period change need unlock
// - unlock bit self-clears four cycles after write
// - reset flag forces reset enable to one
// - period select is bit5 plus bits 2:0
// - codes 0..9 give 2048 doubling to 1048576
// - programmed fuse holds reset enable 1, irq 0
// - counter counts oscillator, restart instruction zeroes it
package wdtc_pkg;

    localparam logic [7:0]  CSR_ADDR      = 8'h60;
    localparam logic [7:0]  CSR_RESET     = 8'h00;
    localparam int unsigned FLAG_BIT      = 7;
    localparam int unsigned IE_BIT        = 6;
    localparam int unsigned PER_HI_BIT    = 5;
    localparam int unsigned CU_BIT        = 4;
    localparam int unsigned RE_BIT        = 3;
    localparam int unsigned PER_LO_MSB    = 2;
    localparam logic [2:0]  UNLOCK_LOAD   = 3'h3; // four cycles: load 3, clear after 0
    localparam logic [2:0]  UNLOCK_ZERO   = 3'h0;
    localparam logic [3:0]  PER_MAX       = 4'h9;
    localparam logic [20:0] BASE_PERIOD   = 21'h000800;
    localparam int unsigned CNT_WIDTH     = 20;

    // mode from {reset_enable, timeout_irq_enable}, gray along stop-irq-both-reset
    typedef enum logic [1:0] {
        WDTC_STOP = 2'h0,
        WDTC_IRQ  = 2'h1,
        WDTC_BOTH = 2'h3,
        WDTC_RST  = 2'h2
    } wdtc_mode_e;

    // last count value of a period; reserved codes take the longest
    function automatic logic [19:0] wdtc_limit(input logic [3:0] sel);
        logic [3:0]  code;
        logic [20:0] full;
        code = (sel > PER_MAX) ? PER_MAX : sel;
        full = BASE_PERIOD << code;
        return 20'(full - 21'h000001);
    endfunction

endpackage

// File: common/wdtc_cnt_if.sv
// carrier between the watchdog control logic and its period counter
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface wdtc_cnt_if;
    logic       osc_tick;
    logic       restart;
    logic       run;
    logic [3:0] period;
    logic       timeout;

    modport ctl (output osc_tick, output restart, output run, output period, input timeout);
    modport cnt (input osc_tick, input restart, input run, input period, output timeout);
endinterface

// File: logic/wdtc_counter.sv
// oscillator cycle counter with selectable timeout
// assumes osc_tick is a one-cycle pulse per oscillator cycle
`timescale 1ns/1ps
module wdtc_counter #(
    parameter int CNT_W = 20
) (
    input  wire logic clk,
    input  wire logic rst_n,
    wdtc_cnt_if.cnt   cbus
);

    if (CNT_W < wdtc_pkg::CNT_WIDTH) begin : g_bad_width
        $error("counter width too small for longest period");
    end

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic             to_r;
    logic             to_nxt;
    logic [19:0]      limit;

    ////////////////////////////////////////////////////////////////////
    // next count and timeout pulse
    always_comb begin
        limit   = wdtc_pkg::wdtc_limit(cbus.period);
        cnt_nxt = cnt_r;
        to_nxt  = 1'b0;
        if (!cbus.run || cbus.restart) begin
            cnt_nxt = '0;
        end else if (cbus.osc_tick) begin
            if (cnt_r >= CNT_W'(limit)) begin
                cnt_nxt = '0;
                to_nxt  = 1'b1;
            end else begin
                cnt_nxt = cnt_r + CNT_W'(1);
            end
        end
    end

    // registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
            to_r  <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            to_r  <= to_nxt;
        end
    end

    assign cbus.timeout = to_r;

    restart_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        cbus.restart |=> cnt_r == '0 && !to_r)
        else $error("restart did not zero the counter");

endmodule

// File: logic/wdtc_top.sv
// watchdog control/status register, mode logic and request outputs
// assumes processor register strobes, oscillator ticks and fuse are synchronous to clk
`timescale 1ns/1ps
module wdtc_top #(
    parameter int CNT_W = 20
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       osc_tick,
    input  wire logic       wdr_exec,
    input  wire logic       irq_vector_taken,
    input  wire logic       global_irq_enable,
    input  wire logic       always_on_fuse,
    input  wire logic       watchdog_reset_flag,
    output logic            irq_req,
    output logic            sys_reset_req
);

    wdtc_cnt_if cbus ();

    logic       flag_r;
    logic       flag_nxt;
    logic       ie_r;
    logic       ie_nxt;
    logic       re_r;
    logic       re_nxt;
    logic       cu_r;
    logic       cu_nxt;
    logic [2:0] cu_cnt_r;
    logic [2:0] cu_cnt_nxt;
    logic [3:0] per_r;
    logic [3:0] per_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic       irq_r;
    logic       irq_nxt;
    logic       rst_r;
    logic       rst_nxt;
    logic       wr_hit;
    logic       fuse_prog;
    logic       re_eff;
    logic       ie_eff;
    logic [7:0] image;
    wdtc_pkg::wdtc_mode_e mode;

    ////////////////////////////////////////////////////////////////////
    // decode, effective enables and mode
    assign wr_hit    = reg_wr && (reg_addr == wdtc_pkg::CSR_ADDR);
    assign fuse_prog = !always_on_fuse;                          // fuse 0 means programmed
    assign re_eff    = re_r | watchdog_reset_flag | fuse_prog;
    assign ie_eff    = ie_r & !fuse_prog;
    assign mode      = fuse_prog ? wdtc_pkg::WDTC_RST
                                 : wdtc_pkg::wdtc_mode_e'({re_eff, ie_eff});
    assign image     = {flag_r, ie_eff, per_r[3], cu_r, re_eff, per_r[2:0]};

    // counter hookup
    assign cbus.osc_tick = osc_tick;
    assign cbus.restart  = wdr_exec;
    assign cbus.run      = (mode != wdtc_pkg::WDTC_STOP);
    assign cbus.period   = per_r;

    wdtc_counter #(
        .CNT_W (CNT_W)
    ) u_counter (
        .clk   (clk),
        .rst_n (rst_n),
        .cbus  (cbus)
    );

    ////////////////////////////////////////////////////////////////////
    // next values of the control/status state
    always_comb begin
        flag_nxt   = flag_r;
        ie_nxt     = ie_r;
        re_nxt     = re_r;
        cu_nxt     = cu_r;
        cu_cnt_nxt = cu_cnt_r;
        per_nxt    = per_r;
        rst_nxt    = 1'b0;
        // unlock window countdown
        if (cu_r) begin
            if (cu_cnt_r == wdtc_pkg::UNLOCK_ZERO) begin
                cu_nxt = 1'b0;
            end else begin
                cu_cnt_nxt = cu_cnt_r - 3'h1;
            end
        end
        // vector entry
        if (irq_vector_taken && flag_r) begin
            flag_nxt = 1'b0;
            if (mode == wdtc_pkg::WDTC_BOTH) begin
                ie_nxt = 1'b0;
            end
        end
        // software write
        if (wr_hit) begin
            if (reg_wdata[wdtc_pkg::FLAG_BIT]) begin
                flag_nxt = 1'b0;
            end
            ie_nxt = reg_wdata[wdtc_pkg::IE_BIT];
            if (reg_wdata[wdtc_pkg::RE_BIT]) begin
                re_nxt = 1'b1;
            end else if (cu_r) begin
                re_nxt = 1'b0;
            end
            if (cu_r) begin
                per_nxt = {reg_wdata[wdtc_pkg::PER_HI_BIT],
                           reg_wdata[wdtc_pkg::PER_LO_MSB:0]};
            end
            cu_nxt = reg_wdata[wdtc_pkg::CU_BIT];
            if (reg_wdata[wdtc_pkg::CU_BIT]) begin
                cu_cnt_nxt = wdtc_pkg::UNLOCK_LOAD;
            end
        end
        // timeout actions, placed after vector entry and software write so a set wins over a clear
        if (cbus.timeout) begin
            case (mode)
                wdtc_pkg::WDTC_IRQ: begin
                    flag_nxt = 1'b1;
                end
                wdtc_pkg::WDTC_RST: begin
                    rst_nxt = 1'b1;
                end
                wdtc_pkg::WDTC_BOTH: begin
                    if (flag_r) begin
                        rst_nxt = 1'b1;
                    end else begin
                        flag_nxt = 1'b1;
                    end
                end
                default: begin
                    rst_nxt = 1'b0;
                end
            endcase
        end
        // fuse locks the enables
        if (fuse_prog) begin
            re_nxt = 1'b1;
            ie_nxt = 1'b0;
        end
        irq_nxt   = flag_nxt & ie_nxt & !fuse_prog & global_irq_enable;
        rdata_nxt = (reg_rd && reg_addr == wdtc_pkg::CSR_ADDR) ? image : 8'h00;
    end

    // registers, all cleared by reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_r   <= wdtc_pkg::CSR_RESET[wdtc_pkg::FLAG_BIT];
            ie_r     <= wdtc_pkg::CSR_RESET[wdtc_pkg::IE_BIT];
            re_r     <= wdtc_pkg::CSR_RESET[wdtc_pkg::RE_BIT];
            cu_r     <= wdtc_pkg::CSR_RESET[wdtc_pkg::CU_BIT];
            cu_cnt_r <= wdtc_pkg::UNLOCK_ZERO;
            per_r    <= 4'h0;
            rdata_r  <= 8'h00;
            irq_r    <= 1'b0;
            rst_r    <= 1'b0;
        end else begin
            flag_r   <= flag_nxt;
            ie_r     <= ie_nxt;
            re_r     <= re_nxt;
            cu_r     <= cu_nxt;
            cu_cnt_r <= cu_cnt_nxt;
            per_r    <= per_nxt;
            rdata_r  <= rdata_nxt;
            irq_r    <= irq_nxt;
            rst_r    <= rst_nxt;
        end
    end

    // outputs straight from flops; reset request feeds the reset-status flag
    assign reg_rdata     = rdata_r;
    assign irq_req       = irq_r;
    assign sys_reset_req = rst_r;

    ////////////////////////////////////////////////////////////////////
    // checks
    flag_on_timeout_a: assert property (@(posedge clk) disable iff (!rst_n)
        cbus.timeout && mode == wdtc_pkg::WDTC_IRQ |=> flag_r && !sys_reset_req)
        else $error("interrupt-mode timeout did not set the flag");

    vector_clears_a: assert property (@(posedge clk) disable iff (!rst_n)
        irq_vector_taken && flag_r && !cbus.timeout |=> !flag_r && !irq_req)
        else $error("vector entry did not clear the flag");

    write_one_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_hit && reg_wdata[wdtc_pkg::FLAG_BIT] && !cbus.timeout |=> !flag_r)
        else $error("writing one did not clear the flag");

    irq_gating_a: assert property (@(posedge clk) disable iff (!rst_n)
        irq_req |-> flag_r && ie_r && $past(global_irq_enable))
        else $error("interrupt raised without flag and enables");

    fuse_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
        !always_on_fuse && cbus.timeout |=> sys_reset_req && !irq_req)
        else $error("fuse-forced timeout did not request reset");

    combined_first_a: assert property (@(posedge clk) disable iff (!rst_n)
        cbus.timeout && mode == wdtc_pkg::WDTC_BOTH && !flag_r |=> flag_r && !sys_reset_req)
        else $error("combined first timeout wrong");

    combined_second_a: assert property (@(posedge clk) disable iff (!rst_n)
        cbus.timeout && mode == wdtc_pkg::WDTC_BOTH && flag_r |=> sys_reset_req)
        else $error("unserviced combined timeout did not reset");

    period_locked_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_hit && !cu_r |=> per_r == $past(per_r))
        else $error("period changed without unlock");

    unlock_expire_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_hit && reg_wdata[wdtc_pkg::CU_BIT] ##1 (!wr_hit && cu_r) [*4] |=> !cu_r)
        else $error("unlock did not expire after four cycles");

    flag_forces_re_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_rd && reg_addr == wdtc_pkg::CSR_ADDR && watchdog_reset_flag
        |=> reg_rdata[wdtc_pkg::RE_BIT])
        else $error("reset enable not forced by reset flag");

endmodule

// File: test/tb.sv
// self-checking bench for the watchdog control block, driven through its register strobes
// assumes one 20 MHz clock; oscillator ticks are made here as one-cycle pulses
`timescale 1ns/1ps
module tb;
    logic       clk;
    logic       rst_n;
    logic [7:0] reg_addr;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic       osc_tick;
    logic       wdr_exec;
    logic       irq_vector_taken;
    logic       global_irq_enable;
    logic       always_on_fuse;
    logic       watchdog_reset_flag;
    logic       irq_req;
    logic       sys_reset_req;
    int         bad_count;
    int         n_checks;
    int         n_rst;
    int         base;

    wdtc_top u_dut (
        .clk                 (clk),
        .rst_n               (rst_n),
        .reg_addr            (reg_addr),
        .reg_wr              (reg_wr),
        .reg_rd              (reg_rd),
        .reg_wdata           (reg_wdata),
        .reg_rdata           (reg_rdata),
        .osc_tick            (osc_tick),
        .wdr_exec            (wdr_exec),
        .irq_vector_taken    (irq_vector_taken),
        .global_irq_enable   (global_irq_enable),
        .always_on_fuse      (always_on_fuse),
        .watchdog_reset_flag (watchdog_reset_flag),
        .irq_req             (irq_req),
        .sys_reset_req       (sys_reset_req)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // clock, reset-request pulse counter, hang guard
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // counted mid-cycle, where the one-cycle request pulse has settled
    always @(negedge clk) begin
        if (sys_reset_req === 1'b1) n_rst <= n_rst + 1;
    end

    initial begin
        repeat (100000) @(posedge clk);
        bad_count++;
        $display("Error at %0t: run timed out", $time);
        final_report();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // access and stimulus tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= wdtc_pkg::CSR_ADDR;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    // registered read data is looked at just after the read edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        chk(reg_rdata, exp, what);
    endtask

    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk);
            osc_tick <= 1'b1;
            @(posedge clk);
            osc_tick <= 1'b0;
        end
        settle();
    endtask

    task automatic restart();
        @(posedge clk);
        wdr_exec <= 1'b1;
        @(posedge clk);
        wdr_exec <= 1'b0;
    endtask

    task automatic vector();
        @(posedge clk);
        irq_vector_taken <= 1'b1;
        @(posedge clk);
        irq_vector_taken <= 1'b0;
        settle();
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {rst_n, reg_wr, reg_rd, osc_tick, wdr_exec, irq_vector_taken} = 6'h00;
        {reg_addr, reg_wdata} = 16'h0000;
        {global_irq_enable, always_on_fuse, watchdog_reset_flag} = 3'h6;
        bad_count = 0;
        n_checks  = 0;
        n_rst     = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd(wdtc_pkg::CSR_ADDR, 8'h00, "reset image");
        rd(8'h61, 8'h00, "unmapped read");
        // stopped mode takes no action
        ticks(2100);
        rd(wdtc_pkg::CSR_ADDR, 8'h00, "stopped flag");
        chk(8'(n_rst), 8'h00, "stopped reset");
        // interrupt mode, shortest period
        wr(8'h40);
        ticks(2047);
        chk(8'(irq_req), 8'h00, "early irq");
        ticks(1);
        chk(8'(irq_req), 8'h01, "irq on timeout");
        rd(wdtc_pkg::CSR_ADDR, 8'hC0, "flag set");
        @(posedge clk) global_irq_enable <= 1'b0;
        settle();
        chk(8'(irq_req), 8'h00, "global gate");
        @(posedge clk) global_irq_enable <= 1'b1;
        wr(8'h40);
        rd(wdtc_pkg::CSR_ADDR, 8'hC0, "zero keeps flag");
        wr(8'hC0);
        rd(wdtc_pkg::CSR_ADDR, 8'h40, "one clears flag");
        chk(8'(irq_req), 8'h00, "irq after clear");
        restart();
        ticks(2048);
        vector();
        rd(wdtc_pkg::CSR_ADDR, 8'h40, "vector clears flag");
        chk(8'(irq_req), 8'h00, "irq after vector");
        // restart in mid-count
        restart();
        ticks(2000);
        restart();
        ticks(2000);
        rd(wdtc_pkg::CSR_ADDR, 8'h40, "restart delays");
        ticks(48);
        rd(wdtc_pkg::CSR_ADDR, 8'hC0, "count from zero");
        wr(8'hC0);
        // combined mode, serviced then unserviced
        wr(8'h48);
        restart();
        ticks(2048);
        rd(wdtc_pkg::CSR_ADDR, 8'hC8, "combined first");
        chk(8'(n_rst), 8'h00, "no reset first");
        vector();
        rd(wdtc_pkg::CSR_ADDR, 8'h08, "vector to reset mode");
        ticks(2048);
        chk(8'(n_rst), 8'h01, "reset mode timeout");
        wr(8'h48);
        restart();
        ticks(2048);
        rd(wdtc_pkg::CSR_ADDR, 8'hC8, "flag pending");
        ticks(2048);
        chk(8'(n_rst), 8'h02, "unserviced reset");
        wr(8'hC8);
        // guarded changes
        wr(8'h00);
        rd(wdtc_pkg::CSR_ADDR, 8'h08, "locked clear");
        wr(8'h09);
        rd(wdtc_pkg::CSR_ADDR, 8'h08, "locked period");
        wr(8'h18);
        rd(wdtc_pkg::CSR_ADDR, 8'h18, "unlock open");
        repeat (4) @(posedge clk);
        wr(8'h00);
        rd(wdtc_pkg::CSR_ADDR, 8'h08, "unlock expired");
        wr(8'h18);
        wr(8'h09);
        rd(wdtc_pkg::CSR_ADDR, 8'h09, "period code one");
        base = n_rst;
        restart();
        ticks(4095);
        chk(8'(n_rst), 8'(base), "early reset");
        ticks(1);
        chk(8'(n_rst), 8'(base + 1), "reset at 4096");
        wr(8'h18);
        wr(8'h28);
        rd(wdtc_pkg::CSR_ADDR, 8'h28, "period high bit");
        wr(8'h18);
        wr(8'h00);
        rd(wdtc_pkg::CSR_ADDR, 8'h00, "turned off");
        // reset flag forces reset enable
        @(posedge clk) watchdog_reset_flag <= 1'b1;
        settle();
        rd(wdtc_pkg::CSR_ADDR, 8'h08, "flag forces enable");
        wr(8'h18);
        wr(8'h00);
        rd(wdtc_pkg::CSR_ADDR, 8'h08, "cannot clear");
        base = n_rst;
        restart();
        ticks(2048);
        chk(8'(n_rst), 8'(base + 1), "flag acts as enable");
        @(posedge clk) watchdog_reset_flag <= 1'b0;
        wr(8'h18);
        wr(8'h00);
        // programmed fuse forces reset mode
        @(posedge clk) always_on_fuse <= 1'b0;
        wr(8'h40);
        rd(wdtc_pkg::CSR_ADDR, 8'h08, "fuse image");
        base = n_rst;
        restart();
        ticks(2048);
        chk(8'(n_rst), 8'(base + 1), "fuse reset");
        rd(wdtc_pkg::CSR_ADDR, 8'h08, "fuse no flag");
        final_report();
    end
endmodule
